// ==== core/spic_socket_ctrl.sv ====
// Socket power and interrupt control registers for one 16-bit card socket
//
// Notes on behaviour
// - Power bit 7 gates 16-bit card outputs other than card reset, which control bit 6 drives alone; reset disables them.
// - Primary layout: power bit 5 enables card-detect driven auto power switching.
// - Primary layout: power bit 4 connects Vcc, then gated by system power bit.
// - Power bits 1-0 request Vpp: off, Vcc, 12 V, reserved.
// - Vpp request is ignored while socket Vcc is off.
// - Extended layout: power bits 4-3 request Vcc: 0 V, 0 V, 5 V, 3.3 V.
// - Reserved power bits read zero and ignore writes, per layout.
// - Control bit 7 switches battery-detect-1 pin to ring indicate.
// - Control bit 6 low asserts card reset, for 16-bit cards only.
// - Control bit 5 records card kind: memory or I/O.
// - Control bit 4 sends status change interrupts to PCI, else by the status change select input.
// - Control bits 3-0 pick functional interrupt: 1 IRQ1, 2 SMI, 9 IRQ9.
// - Select 0000 routes nothing and forces status change interrupts to PCI.
// - Writing 0010 into the revision field selects the primary layout.
// - Interface status bit 6 shows whether socket power is on.
// - With ring indicate on, status-change bit 0 shows the ring input.
`timescale 1ns/1ps
module spic_socket_ctrl (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_ce,
   input  wire logic        i_reg_wr,
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic [7:0]  i_reg_wdata,
   output logic      [7:0]  o_reg_rdata,
   input  wire logic        i_system_power_gate,
   input  wire logic        i_card_is_16bit,
   input  wire logic        i_battery_detect1_ring_pin,
   input  wire logic        i_battery_dead_flag,
   input  wire logic        i_card_irq_pin,
   input  wire logic        i_card_status_change,
   input  wire logic [3:0]  i_status_change_irq_select,
   output logic             o_card_output_enable,
   output logic             o_auto_power_switch_enable,
   output logic             o_socket_vcc_enable,
   output logic      [1:0]  o_vcc_request,
   output logic      [1:0]  o_vpp_request,
   output logic             o_ring_indicate_enable,
   output logic             o_card_reset,
   output logic             o_card_kind,
   output logic             o_csc_pci_irq,
   output logic      [15:0] o_csc_isa_irq,
   output logic      [15:0] o_io_isa_irq,
   output logic             o_io_smi
);
   logic [7:0]           pwr_ff;
   logic [7:0]           igc_ff;
   logic [3:0]           rev_ff;
   logic [7:0]           rdata_ff;
   logic [1:0]           pin_lvl;
   logic                 primary;
   logic [7:0]           pwr_mask;
   logic                 wr_pwr;
   logic                 wr_igc;
   logic                 wr_rev;
   logic [7:0]           nxt_pwr;
   logic [7:0]           nxt_igc;
   logic [7:0]           nxt_rdata;
   logic [3:0]           io_sel;
   logic                 csc_to_pci;
   logic                 ring_lvl;
   logic                 irq_lvl;
   spic_pkg::spic_power_t pwr;
   spic_pkg::spic_wreq_t  wreq;

   // One-hot IRQ line for a select code; code 0 and the SMI code give no line
   function automatic logic [15:0] irq_onehot(input logic [3:0] code);
      logic [15:0] v;
      v = 16'h0001 << code;
      if (code == spic_pkg::SEL_NONE || code == spic_pkg::SEL_SMI) begin
         v = 16'h0000;
      end
      return v;
   endfunction

   // Pins from the card are synchronised
   spic_pin_sync #(
      .WIDTH (2)
   ) u_pin_sync (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_ce    (i_ce),
      .i_pin   ({i_card_irq_pin, i_battery_detect1_ring_pin}),
      .o_level (pin_lvl)
   );
   assign ring_lvl = pin_lvl[0];
   assign irq_lvl  = pin_lvl[1];

   // Write decode and layout selection
   assign wreq     = '{wr: i_reg_wr, addr: i_reg_addr, data: i_reg_wdata};
   assign wr_pwr   = i_ce && wreq.wr && (wreq.addr == spic_pkg::OFS_POWER);
   assign wr_igc   = i_ce && wreq.wr && (wreq.addr == spic_pkg::OFS_IRQ_GEN);
   assign wr_rev   = i_ce && wreq.wr && (wreq.addr == spic_pkg::OFS_IDENT);
   assign primary  = (rev_ff == spic_pkg::REV_PRIMARY);
   assign pwr_mask = primary ? spic_pkg::PWR_MASK_PRIM : spic_pkg::PWR_MASK_EXT;
   assign nxt_pwr  = (pwr_ff & ~pwr_mask) | (wreq.data & pwr_mask);
   assign nxt_igc  = wreq.data;

   // Register storage
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pwr_ff <= spic_pkg::PWR_RESET;
         igc_ff <= spic_pkg::IGC_RESET;
         rev_ff <= spic_pkg::REV_RESET;
      end else begin
         if (wr_pwr) pwr_ff <= nxt_pwr;
         if (wr_igc) igc_ff <= nxt_igc;
         if (wr_rev) rev_ff <= wreq.data[3:0];
      end
   end

   // Power decode by layout
   assign pwr.output_enable = pwr_ff[spic_pkg::PWR_OE_BIT];
   assign pwr.auto_switch   = primary & pwr_ff[spic_pkg::PWR_AUTO_BIT];
   assign pwr.vcc_request   = primary ? 2'h0 :
                              pwr_ff[spic_pkg::PWR_VCC_LSB +: 2];
   assign pwr.vcc_on        = primary ?
                              (pwr_ff[spic_pkg::PWR_VCCEN_BIT] & i_system_power_gate) :
                              (pwr.vcc_request == spic_pkg::VCC_5V ||
                               pwr.vcc_request == spic_pkg::VCC_3V3);
   assign pwr.vpp_request   = pwr.vcc_on ? pwr_ff[spic_pkg::PWR_VPP_LSB +: 2] :
                              spic_pkg::VPP_OFF;

   assign o_card_output_enable       = pwr.output_enable;
   assign o_auto_power_switch_enable = pwr.auto_switch;
   assign o_socket_vcc_enable        = pwr.vcc_on;
   assign o_vcc_request              = pwr.vcc_request;
   assign o_vpp_request              = pwr.vpp_request;

   // General control and interrupt routing
   assign o_ring_indicate_enable = igc_ff[spic_pkg::IGC_RING_BIT];
   assign o_card_reset = ~igc_ff[spic_pkg::IGC_RST_BIT] & i_card_is_16bit;
   assign o_card_kind  = igc_ff[spic_pkg::IGC_KIND_BIT];
   assign io_sel       = igc_ff[spic_pkg::IGC_SEL_LSB +: 4];
   assign csc_to_pci   = igc_ff[spic_pkg::IGC_ROUTE_BIT] |
                         (io_sel == spic_pkg::SEL_NONE);
   assign o_csc_pci_irq = csc_to_pci & i_card_status_change;
   assign o_csc_isa_irq = csc_to_pci ? 16'h0000 :
                          (irq_onehot(i_status_change_irq_select) &
                           {16{i_card_status_change}});
   assign o_io_isa_irq = irq_onehot(io_sel) & {16{irq_lvl}};
   assign o_io_smi     = (io_sel == spic_pkg::SEL_SMI) & irq_lvl;

   // Read mux; unmapped offsets read zero
   always_comb begin
      nxt_rdata = 8'h00;
      case (i_reg_addr)
         spic_pkg::OFS_IDENT:      nxt_rdata = {spic_pkg::IDENT_IFTYPE, 2'h0, rev_ff};
         spic_pkg::OFS_IF_STATUS:  nxt_rdata[spic_pkg::IFS_PWR_BIT] = pwr.vcc_on;
         spic_pkg::OFS_POWER:      nxt_rdata = pwr_ff & pwr_mask;
         spic_pkg::OFS_IRQ_GEN:    nxt_rdata = igc_ff;
         spic_pkg::OFS_CSC_STATUS: nxt_rdata[spic_pkg::CSC_BIT0] =
                                   o_ring_indicate_enable ? ring_lvl :
                                   i_battery_dead_flag;
         default:                  nxt_rdata = 8'h00;
      endcase
   end

   // Read data register
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rdata_ff <= 8'h00;
      end else if (i_ce) begin
         rdata_ff <= nxt_rdata;
      end
   end
   assign o_reg_rdata = rdata_ff;

   // Checks
   oe_gate_a: assert property (@(posedge i_clk) disable iff (i_rst)
      wr_pwr |=> o_card_output_enable == $past(i_reg_wdata[7]))
      else $error("output enable not bit 7");
   auto_sw_a: assert property (@(posedge i_clk) disable iff (i_rst)
      !primary |-> !o_auto_power_switch_enable) else $error("auto switch in ext layout");
   vpp_ignore_a: assert property (@(posedge i_clk) disable iff (i_rst)
      !o_socket_vcc_enable |-> o_vpp_request == 2'h0) else $error("vpp without vcc");
   pwr_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
      wr_pwr && primary |=> pwr_ff == (($past(i_reg_wdata) & spic_pkg::PWR_MASK_PRIM) |
                                       ($past(pwr_ff) & ~spic_pkg::PWR_MASK_PRIM)))
      else $error("power write wrong");
   rsv_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
      i_ce && i_reg_addr == 8'h02 && primary && !wr_rev |=> (o_reg_rdata & 8'h4C) == 8'h00)
      else $error("reserved power bits read nonzero");
   igc_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
      wr_igc |=> igc_ff == $past(i_reg_wdata)) else $error("control write lost");
   reset_drv_a: assert property (@(posedge i_clk) disable iff (i_rst)
      wr_igc |=> o_card_reset == (!$past(i_reg_wdata[6]) && i_card_is_16bit))
      else $error("card reset wrong");
   csc_force_a: assert property (@(posedge i_clk) disable iff (i_rst)
      igc_ff[3:0] == 4'h0 |-> o_csc_isa_irq == 16'h0000 && o_io_isa_irq == 16'h0000)
      else $error("select zero routed");
   smi_route_a: assert property (@(posedge i_clk) disable iff (i_rst)
      igc_ff[3:0] == 4'h2 |-> o_io_smi == irq_lvl && o_io_isa_irq == 16'h0000)
      else $error("smi route wrong");
   pwr_stat_a: assert property (@(posedge i_clk) disable iff (i_rst)
      i_ce && i_reg_addr == 8'h01 |=> o_reg_rdata[6] == $past(pwr.vcc_on))
      else $error("power status wrong");

   // Checks on routing, layout decode and clock enable
   ce_freeze_a: assert property (@(posedge i_clk) disable iff (i_rst)
      !i_ce |=> pwr_ff == $past(pwr_ff) && igc_ff == $past(igc_ff) && rev_ff == $past(rev_ff))
      else $error("state moved with clock enable low");
   vcc_ext_a: assert property (@(posedge i_clk) disable iff (i_rst)
      !primary |-> o_vcc_request == pwr_ff[4:3] && o_socket_vcc_enable == pwr_ff[4])
      else $error("extended vcc request wrong");
   vcc_prim_a: assert property (@(posedge i_clk) disable iff (i_rst)
      primary |-> o_vcc_request == 2'h0 &&
                  o_socket_vcc_enable == (pwr_ff[4] && i_system_power_gate))
      else $error("primary vcc enable wrong");
   route_pci_a: assert property (@(posedge i_clk) disable iff (i_rst)
      igc_ff[4] |-> o_csc_isa_irq == 16'h0000 && o_csc_pci_irq == i_card_status_change)
      else $error("status change not on pci route");
   ring_en_a: assert property (@(posedge i_clk) disable iff (i_rst)
      wr_igc |=> o_ring_indicate_enable == $past(i_reg_wdata[7]))
      else $error("ring indicate enable lost");
   card_kind_a: assert property (@(posedge i_clk) disable iff (i_rst)
      wr_igc |=> o_card_kind == $past(i_reg_wdata[5]))
      else $error("card kind lost");
   ring_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
      i_ce && i_reg_addr == spic_pkg::OFS_CSC_STATUS && o_ring_indicate_enable |=>
      o_reg_rdata[0] == $past(ring_lvl)) else $error("ring status read wrong");
   irq9_route_a: assert property (@(posedge i_clk) disable iff (i_rst)
      igc_ff[3:0] == 4'h9 |-> o_io_isa_irq == {6'h00, irq_lvl, 9'h000} && !o_io_smi)
      else $error("irq9 route wrong");
endmodule

// ==== core/spic_pkg.sv ====
// Package: offsets, field positions, reset values and carrier types of the socket control bank
package spic_pkg;
   // Register offsets
   localparam logic [7:0] OFS_IDENT      = 8'h00;
   localparam logic [7:0] OFS_IF_STATUS  = 8'h01;
   localparam logic [7:0] OFS_POWER      = 8'h02;
   localparam logic [7:0] OFS_IRQ_GEN    = 8'h03;
   localparam logic [7:0] OFS_CSC_STATUS = 8'h04;
   // Power control field positions
   localparam int         PWR_OE_BIT     = 7;
   localparam int         PWR_AUTO_BIT   = 5;
   localparam int         PWR_VCCEN_BIT  = 4;
   localparam int         PWR_VCC_LSB    = 3;
   localparam int         PWR_VPP_LSB    = 0;
   // Writable masks per layout
   localparam logic [7:0] PWR_MASK_PRIM  = 8'hB3;
   localparam logic [7:0] PWR_MASK_EXT   = 8'h9B;
   // Interrupt and general control field positions
   localparam int         IGC_RING_BIT   = 7;
   localparam int         IGC_RST_BIT    = 6;
   localparam int         IGC_KIND_BIT   = 5;
   localparam int         IGC_ROUTE_BIT  = 4;
   localparam int         IGC_SEL_LSB    = 0;
   // Status bit positions
   localparam int         IFS_PWR_BIT    = 6;
   localparam int         CSC_BIT0       = 0;
   // Identification
   localparam logic [1:0] IDENT_IFTYPE   = 2'h2;
   localparam logic [3:0] REV_PRIMARY    = 4'h2;
   localparam logic [3:0] REV_RESET      = 4'h4;
   // Reset values
   localparam logic [7:0] PWR_RESET      = 8'h00;
   localparam logic [7:0] IGC_RESET      = 8'h00;
   // Select codes
   localparam logic [3:0] SEL_NONE       = 4'h0;
   localparam logic [3:0] SEL_SMI        = 4'h2;
   // Vpp and Vcc encodings
   localparam logic [1:0] VPP_OFF        = 2'h0;
   localparam logic [1:0] VCC_5V         = 2'h2;
   localparam logic [1:0] VCC_3V3        = 2'h3;

   // Register write request
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] data;
   } spic_wreq_t;

   // Decoded socket power controls
   typedef struct packed {
      logic       output_enable;
      logic       auto_switch;
      logic       vcc_on;
      logic [1:0] vcc_request;
      logic [1:0] vpp_request;
   } spic_power_t;
endpackage

// ==== core/spic_pin_sync.sv ====
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module spic_pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire logic             i_ce,
   input  wire logic [WIDTH-1:0] i_pin,
   output logic      [WIDTH-1:0] o_level
);
   logic [WIDTH-1:0] s1_ff;
   logic [WIDTH-1:0] s2_ff;
   logic [WIDTH-1:0] s3_ff;
   logic [WIDTH-1:0] lvl_ff;

   // Elaboration check on width
   if (WIDTH < 1) begin : g_bad_width
      $error("spic_pin_sync: WIDTH must be at least 1");
   end

   // Shift chain; stage one feeds only stage two
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s1_ff  <= '0;
         s2_ff  <= '0;
         s3_ff  <= '0;
         lvl_ff <= '0;
      end else if (i_ce) begin
         s1_ff <= i_pin;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         for (int k = 0; k < WIDTH; k++) begin
            if (s2_ff[k] == s3_ff[k]) begin
               lvl_ff[k] <= s3_ff[k];
            end
         end
      end
   end

   assign o_level = lvl_ff;
endmodule

// ==== verif/spic_card_model.sv ====
// Behavioural card sitting in the socket, 16-bit or another kind set by the bench: interrupt and ring pins
`timescale 1ns/1ps
module spic_card_model (
   input  wire logic i_clk,
   input  wire logic i_card_reset,
   input  wire logic i_irq_req,
   input  wire logic i_ring_req,
   input  wire logic i_is_16bit_req,
   output logic      o_is_16bit,
   output logic      o_irq_pin,
   output logic      o_ring_pin
);
   // Card kind is chosen by the bench so other card types can be inserted
   assign o_is_16bit = i_is_16bit_req;
   // A card held in reset cannot raise its functional interrupt
   always_ff @(posedge i_clk) begin
      o_irq_pin  <= i_irq_req & ~i_card_reset;
      o_ring_pin <= i_ring_req;
   end
endmodule

// ==== verif/spic_socket_ctrl_tb.sv ====
// Self-checking bench for the socket power and interrupt control registers
`timescale 1ns/1ps
module spic_socket_ctrl_tb;
   logic        i_clk, i_rst, reg_wr, gate, bat_dead, csc_ev, irq_req, ring_req;
   logic        card_rst, oe, auto, vcc_en, ring_en, kind, csc_pci, smi;
   logic        is16, irq_pin, ring_pin, ce, card16;
   logic [7:0]  addr, wdata, rdata;
   logic [3:0]  csc_sel;
   logic [1:0]  vcc_req, vpp_req;
   logic [15:0] csc_isa, io_isa;
   int          err_count, checked;

   spic_socket_ctrl u_spic_socket_ctrl (
      .i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_reg_wr(reg_wr),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
      .i_system_power_gate(gate), .i_card_is_16bit(is16),
      .i_battery_detect1_ring_pin(ring_pin), .i_battery_dead_flag(bat_dead),
      .i_card_irq_pin(irq_pin), .i_card_status_change(csc_ev),
      .i_status_change_irq_select(csc_sel), .o_card_output_enable(oe),
      .o_auto_power_switch_enable(auto), .o_socket_vcc_enable(vcc_en),
      .o_vcc_request(vcc_req), .o_vpp_request(vpp_req),
      .o_ring_indicate_enable(ring_en), .o_card_reset(card_rst), .o_card_kind(kind),
      .o_csc_pci_irq(csc_pci), .o_csc_isa_irq(csc_isa), .o_io_isa_irq(io_isa),
      .o_io_smi(smi));

   spic_card_model u_spic_card_model (
      .i_clk(i_clk), .i_card_reset(card_rst), .i_irq_req(irq_req),
      .i_ring_req(ring_req), .i_is_16bit_req(card16), .o_is_16bit(is16), .o_irq_pin(irq_pin),
      .o_ring_pin(ring_pin));

   // Free-running 50 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Register write, held for one enabled edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      addr   <= a;
      wdata  <= d;
      reg_wr <= 1'b1;
      @(posedge i_clk);
      reg_wr <= 1'b0;
      #1;
   endtask

   // Register read with one cycle of latency, then compare
   task automatic rchk(input logic [7:0] a, input logic [15:0] e);
      @(posedge i_clk);
      addr <= a;
      @(posedge i_clk);
      #1;
      chk({8'h00, rdata}, e);
   endtask

   task automatic report_and_stop;
      $display("checks=%0d errors=%0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic t_reset;
      @(posedge i_clk);
      i_rst <= 1'b1;
      repeat (20) @(posedge i_clk);
      i_rst <= 1'b0;
      rchk(8'h02, 16'h0000);
      rchk(8'h03, 16'h0000);
      chk({oe, card_rst}, 16'h0001);
   endtask

   task automatic t_ext_power;
      wr(8'h02, 8'hFF);
      rchk(8'h02, 16'h009B);
      chk({oe, auto, vcc_en, vcc_req, vpp_req}, 16'h005F);
      wr(8'h02, 8'h8A);
      chk({vcc_en, vcc_req, vpp_req}, 16'h0004);
      rchk(8'h01, 16'h0000);
      wr(8'h02, 8'h12);
      chk({oe, vcc_en, vcc_req, vpp_req}, 16'h001A);
      rchk(8'h01, 16'h0040);
   endtask

   task automatic t_primary;
      wr(8'h00, 8'h02);
      rchk(8'h00, 16'h0082);
      wr(8'h02, 8'hFF);
      rchk(8'h02, 16'h00B3);
      chk({auto, vcc_en, vcc_req, vpp_req}, 16'h0033);
      @(posedge i_clk);
      gate <= 1'b0;
      @(posedge i_clk);
      #1;
      chk({vcc_en, vpp_req}, 16'h0000);
      @(posedge i_clk);
      gate <= 1'b1;
      wr(8'h02, 8'h01);
      chk({auto, vcc_en, vpp_req}, 16'h0000);
      wr(8'h00, 8'h04);
   endtask

   task automatic t_control;
      @(posedge i_clk);
      irq_req <= 1'b1;
      wr(8'h03, 8'hE0);
      chk({ring_en, card_rst, kind}, 16'h0005);
      rchk(8'h03, 16'h00E0);
      @(posedge i_clk);
      ring_req <= 1'b1;
      bat_dead <= 1'b0;
      repeat (6) @(posedge i_clk);
      rchk(8'h04, 16'h0001);
      @(posedge i_clk);
      ring_req <= 1'b0;
      bat_dead <= 1'b1;
      repeat (6) @(posedge i_clk);
      rchk(8'h04, 16'h0000);
      wr(8'h03, 8'h60);
      rchk(8'h04, 16'h0001);
      @(posedge i_clk);
      bat_dead <= 1'b0;
   endtask

   // Walk every functional interrupt select code
   task automatic t_irq;
      logic [15:0] e;
      csc_ev <= 1'b1;
      for (int c = 0; c < 16; c++) begin
         wr(8'h03, 8'h40 | 8'(c));
         e = (c == 0 || c == 2) ? 16'h0000 : 16'h0001 << c;
         chk(io_isa, e);
         chk({15'h0000, smi}, {15'h0000, c == 2});
         chk({15'h0000, csc_pci}, {15'h0000, c == 0});
         chk(csc_isa, (c == 0) ? 16'h0000 : 16'h0020);
      end
      wr(8'h03, 8'h51);
      chk({15'h0000, csc_pci}, 16'h0001);
      chk(csc_isa, 16'h0000);
   endtask

   // Clock enable low freezes state and read data; other card types see no reset
   task automatic t_freeze;
      @(posedge i_clk);
      card16 <= 1'b0;
      ce     <= 1'b0;
      addr   <= 8'h00;
      wdata  <= 8'h02;
      reg_wr <= 1'b1;
      repeat (2) @(posedge i_clk);
      #1;
      chk({15'h0000, card_rst}, 16'h0000);
      chk({8'h00, rdata}, 16'h0000);
      @(posedge i_clk);
      ce     <= 1'b1;
      reg_wr <= 1'b0;
      card16 <= 1'b1;
      @(posedge i_clk);
      #1;
      chk({8'h00, rdata}, 16'h0084);
      chk({15'h0000, card_rst}, 16'h0001);
   endtask

   // Main sequence
   initial begin
      i_rst = 1'b1;
      reg_wr = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      gate = 1'b1;
      bat_dead = 1'b0;
      csc_ev = 1'b0;
      irq_req = 1'b0;
      ring_req = 1'b0;
      csc_sel = 4'h5;
      ce = 1'b1;
      card16 = 1'b1;
      err_count = 0;
      checked = 0;
      t_reset();
      t_ext_power();
      t_primary();
      t_control();
      t_irq();
      t_reset();
      t_freeze();
      report_and_stop();
   end

   // Watchdog against a hung run
   initial begin
      repeat (3000) @(posedge i_clk);
      err_count++;
      report_and_stop();
   end
endmodule
